// File: inc/wdt_pkg.sv
// constants shared by the protected watchdog timer
package wdt_pkg;
  // clocking
  localparam int unsigned CORE_FREQ_HZ = 20000000;
  localparam int unsigned LOCO_FREQ_HZ = 125000;
  localparam int unsigned LOCO_DIV = CORE_FREQ_HZ / LOCO_FREQ_HZ;
  localparam int unsigned DIV_W = 8;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(LOCO_DIV - 1);

  // watchdog counter
  localparam int unsigned CNT_W = 12;
  localparam logic [CNT_W-1:0] CNT_RELOAD = 12'hfff;
  localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;

  // register bus
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam logic [ADDR_W-1:0] REFRESH_ADDR = 16'h0000;
  localparam logic [ADDR_W-1:0] START_ADDR = 16'h0001;
  localparam logic [ADDR_W-1:0] PROTECT_ADDR = 16'h0002;
  localparam logic [ADDR_W-1:0] CLKMODE1_ADDR = 16'h0003;
  localparam logic [ADDR_W-1:0] PROCMODE1_ADDR = 16'h0004;
  localparam logic [ADDR_W-1:0] STATUS_ADDR = 16'h0005;
  localparam logic [ADDR_W-1:0] MASK_ADDR = 16'h0006;
  localparam logic [ADDR_W-1:0] COUNT_LO_ADDR = 16'h0007;
  localparam logic [ADDR_W-1:0] COUNT_HI_ADDR = 16'h0008;
  localparam logic [ADDR_W-1:0] OPTION_ADDR = 16'hffff;

  // refresh sequence values
  localparam logic [DATA_W-1:0] REFRESH_FIRST = 8'h00;
  localparam logic [DATA_W-1:0] REFRESH_SECOND = 8'hff;

  // field positions
  localparam int unsigned OPT_AUTOSTART_BIT = 0;
  localparam int unsigned OPT_PROT_INIT_BIT = 7;
  localparam int unsigned PROT_ENABLE_BIT = 7;
  localparam int unsigned STOP_REQ_BIT = 0;
  localparam int unsigned OSC_DIS_BIT = 4;
  localparam int unsigned UF_RST_SEL_BIT = 2;
  localparam int unsigned EV_UNDERFLOW_BIT = 0;
  localparam int unsigned EV_REFRESH_BIT = 1;
  localparam int unsigned EV_STOP_REFUSED_BIT = 2;
  localparam int unsigned EV_W = 3;

  // reset values
  localparam logic [EV_W-1:0] MASK_RESET = 3'h0;
  localparam logic [DATA_W-1:0] OPTION_RESET = 8'hff;
endpackage : wdt_pkg

// File: hw/lowspeed_tick_divider.sv
// divider that makes the low-speed oscillator tick as a one-cycle enable
`timescale 1ns/1ps
module lowspeed_tick_divider (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic run_in,
  output logic tick_out
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [DIV_W-1:0] count;
    logic tick;
  } div_state_s;

  div_state_s state;
  div_state_s next_state;

  always_comb begin
    next_state = state;
    next_state.tick = 1'b0;
    // a stopped oscillator restarts a full period later, no short tick
    if (!run_in) begin
      next_state.count = '0;
    end else if (state.count == DIV_LAST) begin
      next_state.count = '0;
      next_state.tick = 1'b1;
    end else begin
      next_state.count = state.count + DIV_W'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign tick_out = state.tick;
endmodule : lowspeed_tick_divider

// File: hw/refresh_unlock.sv
// detector for the two-write refresh sequence
`timescale 1ns/1ps
module refresh_unlock (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic write_in,
  input wire logic [wdt_pkg::DATA_W-1:0] data_in,
  output logic reload_out
);
  import wdt_pkg::*;

  typedef struct packed {
    logic armed;
  } unlock_state_s;

  unlock_state_s state;
  unlock_state_s next_state;

  always_comb begin
    next_state = state;
    reload_out = 1'b0;
    if (write_in) begin
      // any other value breaks the sequence
      next_state.armed = (data_in == REFRESH_FIRST);
      if (state.armed && data_in == REFRESH_SECOND) begin
        reload_out = 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end
endmodule : refresh_unlock

// File: hw/protected_watchdog_timer.sv
// watchdog timer with count source protection and its control registers
//
// Our own choice: the strobed register port.
`timescale 1ns/1ps
module protected_watchdog_timer (
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [wdt_pkg::ADDR_W-1:0] addr_in,
  input wire logic [wdt_pkg::DATA_W-1:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [wdt_pkg::DATA_W-1:0] option_byte_in,
  input wire logic wait_mode_in,
  output logic [wdt_pkg::DATA_W-1:0] rdata_out,
  output logic wdt_reset_out,
  output logic wdt_irq_out,
  output logic stop_mode_out,
  output logic lowspeed_osc_off_out,
  output logic running_out
);
  import wdt_pkg::*;

  typedef struct packed {
    logic [DATA_W-1:0] option;
    logic protect;
    logic stop_req;
    logic osc_dis;
    logic uf_rst_sel;
    logic running;
    logic [CNT_W-1:0] count;
    logic [EV_W-1:0] status;
    logic [EV_W-1:0] mask;
    logic rst_pulse;
    logic [DATA_W-1:0] rdata;
  } wdt_state_s;

  wdt_state_s state;
  wdt_state_s next_state;

  logic tick;
  logic reload_seq;
  logic refresh_wr;
  logic start_wr;
  logic protect_wr;
  logic clkmode_wr;
  logic procmode_wr;
  logic mask_wr;
  logic status_rd;
  logic protect_rise;
  logic count_en;
  logic underflow;
  logic [EV_W-1:0] events;
  logic [DATA_W-1:0] read_mux;

  // address decode
  assign refresh_wr = write_in && addr_in == REFRESH_ADDR;
  assign start_wr = write_in && addr_in == START_ADDR;
  assign protect_wr = write_in && addr_in == PROTECT_ADDR;
  assign clkmode_wr = write_in && addr_in == CLKMODE1_ADDR;
  assign procmode_wr = write_in && addr_in == PROCMODE1_ADDR;
  assign mask_wr = write_in && addr_in == MASK_ADDR;
  assign status_rd = read_in && addr_in == STATUS_ADDR;

  // oscillator tick; runs while the disable bit is clear
  lowspeed_tick_divider u_tick (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .run_in(!state.osc_dis),
    .tick_out(tick)
  );

  refresh_unlock u_unlock (
    .core_clk_in(core_clk_in),
    .rst_in(rst_in),
    .write_in(refresh_wr),
    .data_in(wdata_in),
    .reload_out(reload_seq)
  );

  // wait mode pauses the count only outside protection mode
  assign count_en = state.running && tick &&
    (state.protect || !wait_mode_in);
  assign underflow = count_en && state.count == CNT_ZERO;
  assign protect_rise = protect_wr && wdata_in[PROT_ENABLE_BIT] &&
    !state.protect;

  always_comb begin
    events = '0;
    events[EV_UNDERFLOW_BIT] = underflow;
    events[EV_REFRESH_BIT] = reload_seq;
    events[EV_STOP_REFUSED_BIT] = clkmode_wr && state.protect &&
      wdata_in[STOP_REQ_BIT];
  end

  always_comb begin
    read_mux = '0;
    unique case (addr_in)
      PROTECT_ADDR: begin
        read_mux[PROT_ENABLE_BIT] = state.protect;
      end
      CLKMODE1_ADDR: begin
        read_mux[STOP_REQ_BIT] = state.stop_req;
        read_mux[OSC_DIS_BIT] = state.osc_dis;
      end
      PROCMODE1_ADDR: begin
        read_mux[UF_RST_SEL_BIT] = state.uf_rst_sel;
      end
      STATUS_ADDR: begin
        read_mux[EV_W-1:0] = state.status;
      end
      MASK_ADDR: begin
        read_mux[EV_W-1:0] = state.mask;
      end
      COUNT_LO_ADDR: begin
        read_mux = state.count[DATA_W-1:0];
      end
      COUNT_HI_ADDR: begin
        read_mux[CNT_W-DATA_W-1:0] = state.count[CNT_W-1:DATA_W];
      end
      OPTION_ADDR: begin
        read_mux = state.option;
      end
      default: begin
        read_mux = '0;
      end
    endcase
  end

  always_comb begin
    next_state = state;
    next_state.rst_pulse = 1'b0;
    next_state.rdata = read_mux;

    // counter
    if (underflow) begin
      next_state.count = CNT_RELOAD;
      // in protection mode the select bit is held at 1
      next_state.rst_pulse = state.uf_rst_sel;
    end else if (count_en) begin
      next_state.count = state.count - CNT_W'(1);
    end
    if (reload_seq) begin
      next_state.count = CNT_RELOAD;
    end

    if (start_wr) begin
      next_state.running = 1'b1;
    end

    // clock mode register: locked bits in protection mode
    if (clkmode_wr && !state.protect) begin
      next_state.stop_req = wdata_in[STOP_REQ_BIT];
      next_state.osc_dis = wdata_in[OSC_DIS_BIT];
    end
    if (procmode_wr && !state.protect) begin
      next_state.uf_rst_sel = wdata_in[UF_RST_SEL_BIT];
    end

    // enabling is one-way; only reset leaves protection mode
    if (protect_rise) begin
      next_state.protect = 1'b1;
      next_state.count = CNT_RELOAD;
      next_state.osc_dis = 1'b0;
      next_state.uf_rst_sel = 1'b1;
    end
    if (!state.option[OPT_PROT_INIT_BIT]) begin
      next_state.protect = 1'b1;
    end

    if (mask_wr) begin
      next_state.mask = wdata_in[EV_W-1:0];
    end
    // read clears, a new event in the same cycle wins
    if (status_rd) begin
      next_state.status = events;
    end else begin
      next_state.status = state.status | events;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      // option byte is static flash content, caught while reset holds
      state <= '0;
      state.option <= option_byte_in;
      state.count <= CNT_RELOAD;
      state.mask <= MASK_RESET;
      state.running <= !option_byte_in[OPT_AUTOSTART_BIT];
      if (!option_byte_in[OPT_PROT_INIT_BIT]) begin
        state.protect <= 1'b1;
        state.uf_rst_sel <= 1'b1;
      end
    end else begin
      state <= next_state;
    end
  end

  assign rdata_out = state.rdata;
  assign wdt_reset_out = state.rst_pulse;
  assign wdt_irq_out = |(state.status & state.mask);
  // refused in protection mode even if requested earlier
  assign stop_mode_out = state.stop_req && !state.protect;
  assign lowspeed_osc_off_out = state.osc_dis;
  assign running_out = state.running;
endmodule : protected_watchdog_timer

// File: verif/protected_watchdog_timer_properties.sv
// port assertions for the protected watchdog timer
`timescale 1ns/1ps
module protected_watchdog_timer_properties
  import wdt_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic [wdt_pkg::ADDR_W-1:0] addr_in,
  input wire logic [wdt_pkg::DATA_W-1:0] wdata_in,
  input wire logic write_in,
  input wire logic read_in,
  input wire logic [wdt_pkg::DATA_W-1:0] option_byte_in,
  input wire logic wait_mode_in,
  input wire logic [wdt_pkg::DATA_W-1:0] rdata_out,
  input wire logic wdt_reset_out,
  input wire logic wdt_irq_out,
  input wire logic stop_mode_out,
  input wire logic lowspeed_osc_off_out,
  input wire logic running_out
);
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  AST_START_RUNS:
    assert property (write_in && addr_in == START_ADDR |=> running_out)
    else $error("start write left counter idle");
  AST_RUN_STICKY:
    assert property (running_out |=> running_out)
    else $error("running counter stopped");
  AST_RESET_RUN:
    assert property ($fell(rst_in) |->
      running_out == !option_byte_in[OPT_AUTOSTART_BIT])
    else $error("run state after reset wrong");
  AST_PROT_OSC_ON:
    assert property (write_in && addr_in == PROTECT_ADDR &&
      wdata_in[PROT_ENABLE_BIT] |=> !lowspeed_osc_off_out)
    else $error("oscillator off after protection");
  AST_PROT_NO_STOP:
    assert property (write_in && addr_in == PROTECT_ADDR &&
      wdata_in[PROT_ENABLE_BIT] |=> !stop_mode_out)
    else $error("stop request under protection");
  AST_STOP_CAUSE:
    assert property ($rose(stop_mode_out) |-> $past(write_in &&
      addr_in == CLKMODE1_ADDR && wdata_in[STOP_REQ_BIT]))
    else $error("stop request without write");
  AST_OSC_CAUSE:
    assert property ($rose(lowspeed_osc_off_out) |-> $past(write_in &&
      addr_in == CLKMODE1_ADDR && wdata_in[OSC_DIS_BIT]))
    else $error("oscillator off without write");
  AST_OPTION_RO:
    assert property (read_in && addr_in == OPTION_ADDR |=>
      rdata_out == $past(option_byte_in))
    else $error("option byte read wrong");
  AST_RESET_PULSE:
    assert property (wdt_reset_out |=> !wdt_reset_out)
    else $error("reset request longer than one cycle");
  COV_START: cover property (write_in && addr_in == START_ADDR);
  COV_REFRESH: cover property (write_in && addr_in == REFRESH_ADDR &&
    wdata_in == REFRESH_SECOND);
  COV_IRQ: cover property ($rose(wdt_irq_out));
endmodule : protected_watchdog_timer_properties

bind protected_watchdog_timer protected_watchdog_timer_properties chk_i (
  .core_clk_in, .rst_in, .addr_in, .wdata_in, .write_in, .read_in,
  .option_byte_in, .wait_mode_in, .rdata_out, .wdt_reset_out, .wdt_irq_out,
  .stop_mode_out, .lowspeed_osc_off_out, .running_out);

// File: verif/protected_watchdog_timer_bench.sv
// self-checking bench for the protected watchdog timer
`timescale 1ns/1ps
module protected_watchdog_timer_bench;
  import wdt_pkg::*;
  logic core_clk_in = 0, rst_in = 1, write_in = 0, read_in = 0;
  logic wait_mode_in = 0, rd_q = 0;
  logic [ADDR_W-1:0] addr_in = '0;
  logic [DATA_W-1:0] wdata_in = '0, option_byte_in = 8'hfe;
  logic [DATA_W-1:0] rdata_out, last_rd;
  logic wdt_reset_out, wdt_irq_out, stop_mode_out;
  logic lowspeed_osc_off_out, running_out;
  logic [DATA_W-1:0] exp_q[$], msk_q[$];
  int n_mismatch = 0, checks = 0, k;
  protected_watchdog_timer dut (.core_clk_in, .rst_in, .addr_in, .wdata_in,
    .write_in, .read_in, .option_byte_in, .wait_mode_in, .rdata_out,
    .wdt_reset_out, .wdt_irq_out, .stop_mode_out, .lowspeed_osc_off_out,
    .running_out);
  initial forever #25 core_clk_in = ~core_clk_in;
  task automatic chk(input string nm, input logic [7:0] e, g);
    checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim
  // one call per cycle, so no strobe is driven twice in a time step
  task automatic bus(input logic w, r, input logic [15:0] a,
    input logic [7:0] d);
    write_in <= w;
    read_in <= r;
    addr_in <= a;
    wdata_in <= d;
    @(posedge core_clk_in);
  endtask : bus
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    bus(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic rd(input logic [15:0] a, input logic [7:0] e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, addr_in, 8'h00);
  endtask : idle
  // output is picked after the wait, a task input would be stale
  task automatic bit_chk(input string nm, input logic e);
    logic g;
    idle(1);
    if (nm == "running") g = running_out;
    else if (nm == "osc_off") g = lowspeed_osc_off_out;
    else if (nm == "stop") g = stop_mode_out;
    else if (nm == "irq") g = wdt_irq_out;
    else g = wdt_reset_out;
    chk(nm, {7'h0, e}, {7'h0, g});
  endtask : bit_chk
  // read results are compared one cycle after the strobe
  always @(posedge core_clk_in) begin
    rd_q <= read_in;
    if (rd_q) begin
      last_rd = rdata_out;
      if (exp_q.size() == 0) chk("read queue", 8'h01, 8'h00);
      else chk("rdata", exp_q.pop_front(), rdata_out & msk_q.pop_front());
    end
  end
  initial begin
    #(50 * 20000);
    n_mismatch++;
    end_sim();
  end
  initial begin
    k = $urandom(32'h56175f74);
    repeat (6) @(posedge core_clk_in);
    rst_in <= 1'b0;
    idle(1);
    bit_chk("running", 1'b1);
    rd(OPTION_ADDR, 8'hfe, 8'hff);
    wr(OPTION_ADDR, 8'h00);
    rd(OPTION_ADDR, 8'hfe, 8'hff);
    idle(400);
    wr(CLKMODE1_ADDR, 8'h10);
    bit_chk("osc_off", 1'b1);
    wr(PROTECT_ADDR, 8'h80);
    rd(COUNT_LO_ADDR, 8'hfe, 8'hfe);
    rd(COUNT_HI_ADDR, 8'h0f, 8'h0f);
    rd(PROCMODE1_ADDR, 8'h04, 8'h04);
    bit_chk("osc_off", 1'b0);
    wr(CLKMODE1_ADDR, 8'h11);
    wr(PROCMODE1_ADDR, 8'h00);
    bit_chk("stop", 1'b0);
    bit_chk("osc_off", 1'b0);
    rd(CLKMODE1_ADDR, 8'h00, 8'h11);
    rd(PROCMODE1_ADDR, 8'h04, 8'h04);
    rd(STATUS_ADDR, 8'h04, 8'h04);
    // count keeps running in wait mode, one step per 160 cycles
    wait_mode_in <= 1'b1;
    k = $urandom_range(40, 1);
    rd(COUNT_LO_ADDR, 8'hf0, 8'hf0);
    idle(160 * k - 1);
    rd(COUNT_LO_ADDR, last_rd - 8'(k), 8'hff);
    wr(MASK_ADDR, 8'h02);
    wr(REFRESH_ADDR, REFRESH_FIRST);
    wr(REFRESH_ADDR, REFRESH_SECOND);
    idle(1);
    bit_chk("irq", 1'b1);
    rd(COUNT_LO_ADDR, 8'hfe, 8'hfe);
    rd(COUNT_HI_ADDR, 8'h0f, 8'h0f);
    rd(STATUS_ADDR, 8'h02, 8'h02);
    idle(1);
    bit_chk("irq", 1'b0);
    wr(MASK_ADDR, 8'h00);
    wr(REFRESH_ADDR, REFRESH_FIRST);
    wr(REFRESH_ADDR, REFRESH_SECOND);
    idle(1);
    bit_chk("irq", 1'b0);
    rd(STATUS_ADDR, 8'h02, 8'h02);
    rd(16'h0010, 8'h00, 8'hff);
    // second boot: autostart off, protection forced by the option
    rst_in <= 1'b1;
    option_byte_in <= 8'h7f;
    idle(6);
    rst_in <= 1'b0;
    idle(1);
    bit_chk("running", 1'b0);
    wr(PROTECT_ADDR, 8'h00);
    rd(PROTECT_ADDR, 8'h80, 8'h80);
    wr(START_ADDR, 8'($urandom));
    bit_chk("running", 1'b1);
    bit_chk("wdt_reset", 1'b0);
    idle(3);
    end_sim();
  end
endmodule : protected_watchdog_timer_bench
